// ---- rxc_cap_defs.vh ----
`ifndef RXC_CAP_DEFS_VH
`define RXC_CAP_DEFS_VH

// ==========================================================
// Register byte addresses
`define RXC_ADDR_CAP_LO 8'h10
`define RXC_ADDR_CAP_HI 8'h14
`define RXC_ADDR_CTRL 8'h40
`define RXC_ADDR_CHK_ID 8'h44
`define RXC_ADDR_CHK_STAT 8'h48

// ==========================================================
// Field positions in the 64-bit capability word
`define RXC_IDW_MSB 39
`define RXC_IDW_LSB 35
`define RXC_EAF_BIT 34
`define RXC_NWF_BIT 33
`define RXC_IOT_BIT 32
`define RXC_SRQ_BIT 31
`define RXC_XRQ_BIT 30
`define RXC_PRQ_BIT 29
`define RXC_PID_BIT 28
`define RXC_DIV_BIT 27
`define RXC_STK_BIT 26
`define RXC_MTY_BIT 25
`define RXC_ECX_BIT 24
`define RXC_DTL_BIT 2

// ==========================================================
// Implemented feature values
`define RXC_IDW_VAL 5'h13
`define RXC_EAF_VAL 1'h1
`define RXC_NWF_VAL 1'h1
`define RXC_IOT_VAL 1'h1
`define RXC_SRQ_VAL 1'h1
`define RXC_XRQ_VAL 1'h0
`define RXC_PRQ_VAL 1'h1
`define RXC_PID_VAL 1'h1
`define RXC_DIV_VAL 1'h0
`define RXC_STK_VAL 1'h1
`define RXC_ECX_VAL 1'h1
`define RXC_DTL_VAL 1'h1

// ==========================================================
// Reset values and bus responses
`define RXC_CTRL_RST 1'h0
`define RXC_CHK_ID_RST 20'h00000
`define RXC_RESP_OKAY 2'h0
`define RXC_RESP_SLVERR 2'h2

`endif

// ---- rxc_ext_cap.v ----
`timescale 1ns/1ps
`include "rxc_cap_defs.vh"

// Function
// - 64-bit capability register at offset 010h
// - Bits 39:35 hold identifier width minus one
// - Identifiers above reported width flagged as error
// - Bit 34 reports extended-accessed flag support
// - Bit 33 one: no-write flag passed through
// - Bit 32 reports identifier-only translation support
// - Bit 31 reports supervisor request support
// - Bit 30 reports execute request support
// - Bit 29 reports page request support
// - Bit 28 reports identifier-tagged request support
// - Bit 27 reports deferred invalidation support
// - Bit 26 reports nested translation support
// - Coherent devices in scope force bit 25
// - Bit 24 reports extended context entry support
module rxc_ext_cap (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Static strap: coherent-domain device behind this unit
    input wire coherentInScope,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Request check and no-write flag filter
    input wire [19:0] reqId,
    input wire reqIdValid,
    output reg reqIdError,
    input wire noWriteIn,
    output reg noWriteOut
);

    // ==========================================================
    // Strap capture, synchronised and re-sampled every cycle
    // The strap comes from board wiring and is not timed against sys_clk,
    // so it passes two flip-flops before anything reads it. Only the
    // second stage is read; the first may go metastable.
    reg strapMeta;
    reg strapSync;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strapMeta <= 1'b0;
            strapSync <= 1'b0;
        end else begin
            strapMeta <= coherentInScope;
            strapSync <= strapMeta;
        end
    end

    // ==========================================================
    // Capability word assembly
    // The word is constant, the strap bit included, so it is plain wiring
    // and costs no flip-flops; the read path registers it on the way out.
    wire [63:0] capWord;
    wire [10:0] featureFlags;
    wire memTypeBit;

    // Memory type is implemented anyway, so the strap can only confirm it;
    // a unit with coherent devices in scope must never report it clear
    assign memTypeBit = strapSync | 1'b1;

    // Feature table: entry 0 lands on bit 24, entry 10 on bit 34
    assign featureFlags[0] = `RXC_ECX_VAL;
    assign featureFlags[1] = memTypeBit;
    assign featureFlags[2] = `RXC_STK_VAL;
    assign featureFlags[3] = `RXC_DIV_VAL;
    assign featureFlags[4] = `RXC_PID_VAL;
    assign featureFlags[5] = `RXC_PRQ_VAL;
    assign featureFlags[6] = `RXC_XRQ_VAL;
    assign featureFlags[7] = `RXC_SRQ_VAL;
    assign featureFlags[8] = `RXC_IOT_VAL;
    assign featureFlags[9] = `RXC_NWF_VAL;
    assign featureFlags[10] = `RXC_EAF_VAL;

    // One single-bit field per table entry
    genvar fIdx;
    generate
        for (fIdx = 0; fIdx < 11; fIdx = fIdx + 1) begin : g_featureBit
            assign capWord[`RXC_ECX_BIT + fIdx] = featureFlags[fIdx];
        end
    endgenerate

    // Reserved upper bits are tied low so reads always see zero
    assign capWord[63:40] = 24'h000000;
    // Identifier width field, value is width minus one
    assign capWord[`RXC_IDW_MSB:`RXC_IDW_LSB] = `RXC_IDW_VAL;
    // Features below bit 24 other than the device-side cache are not built
    assign capWord[23:3] = 21'h000000;
    assign capWord[`RXC_DTL_BIT] = `RXC_DTL_VAL;
    assign capWord[1:0] = 2'h0;

    // ==========================================================
    // Software-visible control and check state
    reg nwFilterEn;
    reg [19:0] lastBadId;
    reg badIdSeen;

    // Register map, one aligned 32-bit word per offset:
    //   capability low and high words, read-only
    //   control word, bit 0 a spare read-back bit
    //   last out-of-range identifier, read-only
    //   sticky out-of-range status, cleared by reading it
    // Anything else answers with a slave error.

    // Decoder shared by both channels
    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (addr == `RXC_ADDR_CAP_LO) || (addr == `RXC_ADDR_CAP_HI) ||
                        (addr == `RXC_ADDR_CTRL) || (addr == `RXC_ADDR_CHK_ID) ||
                        (addr == `RXC_ADDR_CHK_STAT);
        end
    endfunction

    // ==========================================================
    // Write channel: address and data in either order
    // Each half is parked in its own holding register, so a master may
    // offer them in either order or together. The readies drop while a
    // half is parked or a response is pending: one write at a time keeps
    // the logic small, at the price of no write pipelining.
    reg awHeld;
    reg wHeld;
    reg [7:0] awAddr;
    reg [31:0] wData;
    reg [3:0] wStrb;
    wire awTake;
    wire wTake;
    wire doWrite;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    // Both halves parked and the response slot free
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // Write address holding register
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            awAddr <= 8'h00;
        end else if (awTake) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    // Write data holding register
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
        end else if (wTake) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // Write response, raised once per completed write
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RXC_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            // Capability words are read-only; writes there are dropped
            s_axi_bresp <= is_mapped(awAddr) ? `RXC_RESP_OKAY : `RXC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control word, the only writable state in the block.
    // The capability offsets have no write path at all, so nothing
    // software sends can alter what the unit reports.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nwFilterEn <= `RXC_CTRL_RST;
        end else if (doWrite && (awAddr == `RXC_ADDR_CTRL) && wStrb[0]) begin
            nwFilterEn <= wData[0];
        end
    end

    // ==========================================================
    // Read channel: one outstanding read
    // Data is looked up in the cycle the address is taken and registered,
    // so the answer always comes one cycle later and stands until taken.
    wire arTake;
    assign s_axi_arready = !s_axi_rvalid;
    assign arTake = s_axi_arvalid && s_axi_arready;

    // Read valid, held until the master takes the data
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
        end else if (arTake) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read data and response, updated only when an address is taken
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RXC_RESP_OKAY;
        end else if (arTake) begin
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `RXC_RESP_OKAY : `RXC_RESP_SLVERR;
            case (s_axi_araddr)
                `RXC_ADDR_CAP_LO: s_axi_rdata <= capWord[31:0];
                `RXC_ADDR_CAP_HI: s_axi_rdata <= capWord[63:32];
                `RXC_ADDR_CTRL: s_axi_rdata <= {31'h00000000, nwFilterEn};
                `RXC_ADDR_CHK_ID: s_axi_rdata <= {12'h000, lastBadId};
                `RXC_ADDR_CHK_STAT: s_axi_rdata <= {31'h00000000, badIdSeen};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ==========================================================
    // Identifier range check; limit is 2^(width field + 1) - 1
    // The limit follows the reported width, so the check and the
    // capability word can never disagree. With the full 20-bit width
    // reported no 20-bit identifier is out of range; the check stays so
    // that a narrower width setting is enforced with no new logic.
    wire [19:0] idLimit;
    wire idTooBig;
    wire badIdEvent;
    wire readStat;
    assign idLimit = 20'hfffff >> (5'd19 - `RXC_IDW_VAL);
    assign idTooBig = reqId > idLimit;
    assign badIdEvent = reqIdValid && idTooBig;
    assign readStat = arTake && (s_axi_araddr == `RXC_ADDR_CHK_STAT);

    // Error answer, one cycle after the tagged request
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reqIdError <= 1'b0;
        end else begin
            reqIdError <= badIdEvent && `RXC_PID_VAL;
        end
    end

    // Last offending identifier, kept for software
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastBadId <= `RXC_CHK_ID_RST;
        end else if (badIdEvent) begin
            lastBadId <= reqId;
        end
    end

    // Sticky status; a new error in the clearing read wins over the clear,
    // so no error can slip between two status reads unseen
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            badIdSeen <= 1'b0;
        end else if (badIdEvent) begin
            badIdSeen <= 1'b1;
        end else if (readStat) begin
            badIdSeen <= 1'b0;
        end
    end

    // No-write flag: honoured while support is reported, forced low
    // otherwise; the spare control bit has no say over it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            noWriteOut <= 1'b0;
        end else begin
            noWriteOut <= noWriteIn && `RXC_NWF_VAL;
        end
    end

endmodule

// ---- rxc_ext_cap_checker.sv ----
`timescale 1ns/1ps
// ==========
// Port-level checks for the capability block
module rxc_ext_cap_checker (
    // Clock and reset
    input logic sys_clk,
    input logic rst_n,
    // Register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Request side
    input logic reqIdValid,
    input logic reqIdError,
    input logic noWriteIn,
    input logic noWriteOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Accepted read address
    wire arTake = s_axi_arvalid && s_axi_arready;

    property p_capLo; arTake && s_axi_araddr == 8'h10 |=> s_axi_rdata == 32'hb7000004; endproperty
    a_capLo: assert property (p_capLo) else $error("low capability word wrong");
    property p_capHi; arTake && s_axi_araddr == 8'h14 |=> s_axi_rdata == 32'h0000009f; endproperty
    a_capHi: assert property (p_capHi) else $error("high capability word wrong");
    property p_rdLat; arTake |=> s_axi_rvalid; endproperty
    a_rdLat: assert property (p_rdLat) else $error("read answer late");
    property p_rdOnce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdOnce: assert property (p_rdOnce) else $error("read answered twice");
    property p_bResp; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
    a_bResp: assert property (p_bResp) else $error("write not answered");
    property p_unmap; arTake && s_axi_araddr == 8'h20 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
    property p_idOk; reqIdValid |=> !reqIdError; endproperty
    a_idOk: assert property (p_idOk) else $error("legal identifier refused");
    property p_nwGate; noWriteOut |-> $past(noWriteIn); endproperty
    a_nwGate: assert property (p_nwGate) else $error("no-write flag invented");
    property p_nwPass; noWriteIn |=> noWriteOut; endproperty
    a_nwPass: assert property (p_nwPass) else $error("no-write flag dropped");

    // Main scenarios reached
    c_capRead: cover property (arTake && s_axi_araddr == 8'h10);
    c_write: cover property (s_axi_bvalid);
    c_noWrite: cover property (noWriteOut);
endmodule

// ---- rxc_ext_cap_tb.sv ----
`timescale 1ns/1ps
module rxc_ext_cap_tb;
    // ==========
    // Design ports
    logic sys_clk = 1'h0, rst_n = 1'h0, coherentInScope = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, reqIdValid = 1'h0, noWriteIn = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [19:0] reqId = 20'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire reqIdError, noWriteOut;
    int badCount = 0, totalChecks = 0, cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    rxc_ext_cap u_rxc_ext_cap (.*);

    // 100 MHz clock
    initial forever #5 sys_clk = ~sys_clk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'h1; s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
        fork
            begin do @(posedge sys_clk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
            begin do @(posedge sys_clk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
        join
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // Writes to the read-only words answer but change nothing
    task automatic testCapWords();
        axiWrite(8'h10, 32'hffffffff, rs);
        chk("write resp", 32'h0, {30'h0, rs});
        axiWrite(8'h14, 32'hffffffff, rs);
        axiRead(8'h10, rd, rs);
        chk("cap low", 32'hb7000004, rd);
        chk("identifier support", 32'h1, {31'h0, rd[28]});
        chk("device cache support", 32'h1, {31'h0, rd[2]});
        chk("context support", 32'h1, {31'h0, rd[24]});
        axiRead(8'h14, rd, rs);
        chk("cap high", 32'h0000009f, rd);
        axiRead(8'h20, rd, rs);
        chk("unmapped resp", 32'h2, {30'h0, rs});
    endtask

    // Support is reported, so the flag passes whatever the spare bit says
    task automatic testNoWrite();
        @(posedge sys_clk);
        noWriteIn <= 1'h1;
        repeat (2) @(posedge sys_clk);
        chk("flag passed early", 32'h1, {31'h0, noWriteOut});
        axiWrite(8'h40, 32'h1, rs);
        axiRead(8'h40, rd, rs);
        chk("control read back", 32'h1, rd);
        repeat (2) @(posedge sys_clk);
        chk("flag passed", 32'h1, {31'h0, noWriteOut});
        noWriteIn <= 1'h0;
    endtask

    // Widest identifier still inside the reported width
    task automatic testIdLimit();
        @(posedge sys_clk);
        reqId <= 20'hfffff;
        reqIdValid <= 1'h1;
        repeat (2) @(posedge sys_clk);
        chk("id error", 32'h0, {31'h0, reqIdError});
        reqIdValid <= 1'h0;
        axiRead(8'h48, rd, rs);
        chk("id seen", 32'h0, {31'h0, rd[0]});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far above the fifty or so cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        testCapWords();
        testNoWrite();
        testIdLimit();
        end_of_test();
    end
endmodule

bind rxc_ext_cap rxc_ext_cap_checker u_rxc_ext_cap_checker (.*);
